// >>> aesmb_consts.svh
// constants for the advanced error status and mask bank
// assumes inclusion by bare name from the bank and its package users
`ifndef AESMB_CONSTS_SVH
`define AESMB_CONSTS_SVH

// register offsets in extended configuration space
`define AESMB_OFS_CAP_ID      12'h100
`define AESMB_OFS_NEXT_VER    12'h102
`define AESMB_OFS_FLAGS       12'h104
`define AESMB_OFS_MASKS       12'h108

// field positions inside the header dword
`define AESMB_NEXT_VER_LSB    16
`define AESMB_VER_W           4
`define AESMB_NEXT_W          12

// fixed read values
`define AESMB_CAP_ID_VAL      16'h0001
`define AESMB_VER_VAL         4'h1
`define AESMB_NEXT_END        12'h000
`define AESMB_NEXT_VC         12'h150

// implemented bit positions
`define AESMB_BIT_UR          20
`define AESMB_BIT_ECRC        19
`define AESMB_BIT_MAL         18
`define AESMB_BIT_OVF         17
`define AESMB_BIT_UNXP        16
`define AESMB_BIT_CA          15
`define AESMB_BIT_CTO         14
`define AESMB_BIT_FC          13
`define AESMB_BIT_PSN         12
`define AESMB_BIT_DLL         4
`define AESMB_IMPL_MASK       32'h001f_f010

// reset values
`define AESMB_FLAGS_RST       32'h0000_0000
`define AESMB_MASKS_RST       32'h0000_0000

// pin synchroniser depth
`define AESMB_SYNC_STAGES     3

`endif

// >>> aesmb_pkg.sv
// types for the advanced error status and mask bank
// assumes aesmb_consts.svh is on the include path
package aesmb_pkg;

    typedef enum logic [1:0] {
        AESMB_SEL_NONE  = 2'b00,
        AESMB_SEL_CAP   = 2'b01,
        AESMB_SEL_FLAGS = 2'b10,
        AESMB_SEL_MASKS = 2'b11
    } aesmb_sel_t;

endpackage

// >>> aesmb_pin_sync.sv
// three-stage synchroniser for an asynchronous pin
// assumes the pin idles high; output follows once stages two and three agree
`timescale 1ns/1ps
`include "aesmb_consts.svh"

module aesmb_pin_sync (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    // pin and clean level
    input  wire logic pin_i,
    output logic      level_o
);
    logic [`AESMB_SYNC_STAGES-1:0] stage_q;
    logic                          level_q;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            stage_q <= {`AESMB_SYNC_STAGES{1'b1}};
            level_q <= 1'b1;
        end else begin
            stage_q <= {stage_q[`AESMB_SYNC_STAGES-2:0], pin_i};
            if (stage_q[1] == stage_q[2]) begin
                level_q <= stage_q[2];
            end
        end
    end

    assign level_o = level_q;
endmodule

// >>> aesmb_bank.sv
// advanced error status and mask register bank of the primary link
// assumes error detectors give one-cycle pulses on ref_clk_i and
// configuration accesses arrive as single-cycle dword strobes
//
// Contract
// R01: capability identifier at 100h is read-only and reads 0001h.
// R02: with virtual channel structure disabled, next pointer reads 000h.
// R03: with virtual channel structure enabled, next pointer reads 150h.
// R04: capability version at 102h reads 1h and is read-only.
// R05: status bits stay set until software writes one; hardware never clears (link, global and power-on reset clear them here).
// R06: unmasked unsupported request sets status bit 20.
// R07: unmasked end-to-end crc error sets status bit 19.
// R08: unmasked malformed packet sets status bit 18.
// R09: unmasked credit overflow by partner sets status bit 17.
// R10: unmasked unmatched completion sets status bit 16.
// R11: unmasked completer abort returned by bridge sets status bit 15.
// R12: unmasked completion time-out sets status bit 14.
// R13: unmasked flow control protocol error sets status bit 13.
// R14: unmasked poisoned packet sets status bit 12.
// R15: unmasked data link protocol error sets status bit 4.
// R16: reserved bits of status and mask read zero, ignore writes.
// R17: masked error sets no status, report, header log or pointer update.
// R18: mask at 108h holds read/write bits 20:12 and 4, default zero.
// R19: status and mask clear on link, global or power-on reset.
// R20: hot reset clears only unmarked state; status and mask bits are kept.
// R21: event and clear in same cycle leave the bit set.
`timescale 1ns/1ps
`include "aesmb_consts.svh"

module aesmb_bank (
    // clock and power-on reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // other reset sources
    input  wire logic        link_reset_i,
    input  wire logic        hot_reset_i,
    input  wire logic        global_reset_pin_n_i,
    // general control input
    input  wire logic        virtual_channel_structure_enable_i,
    // configuration access
    input  wire logic        cfg_rd_i,
    input  wire logic        cfg_wr_i,
    input  wire logic [11:0] cfg_addr_i,
    input  wire logic [3:0]  cfg_be_i,
    input  wire logic [31:0] cfg_wdata_i,
    output logic      [31:0] cfg_rdata_o,
    output logic             cfg_rvalid_o,
    // error detector pulses
    input  wire logic        unsupported_request_flag_i,
    input  wire logic        end_to_end_crc_flag_i,
    input  wire logic        malformed_packet_flag_i,
    input  wire logic        credit_overflow_flag_i,
    input  wire logic        unmatched_completion_flag_i,
    input  wire logic        completer_abort_flag_i,
    input  wire logic        completion_timeout_flag_i,
    input  wire logic        flow_control_protocol_flag_i,
    input  wire logic        poisoned_packet_flag_i,
    input  wire logic        link_protocol_flag_i,
    // state toward reporting logic
    output logic      [31:0] error_flags_o,
    output logic      [31:0] error_suppress_o,
    output logic      [31:0] error_report_o
);
    import aesmb_pkg::*;

    ////////////////////////////////////////////////////////////////////////

    function automatic logic [31:0] lane_bits(input logic [3:0] be);
        lane_bits = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic [9:0] dword_of(input logic [11:0] ofs);
        dword_of = ofs[11:2];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // reset gathering

    logic global_level;
    logic bank_clear;

    aesmb_pin_sync u_global_sync (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .pin_i     (global_reset_pin_n_i),
        .level_o   (global_level)
    );

    assign bank_clear = rst_i | link_reset_i | !global_level; // R19

    ////////////////////////////////////////////////////////////////////////
    // event word

    logic [31:0] evt_word;

    always_comb begin
        evt_word                      = 32'h0000_0000;
        evt_word[`AESMB_BIT_UR]   = unsupported_request_flag_i;   // R06
        evt_word[`AESMB_BIT_ECRC] = end_to_end_crc_flag_i;        // R07
        evt_word[`AESMB_BIT_MAL]  = malformed_packet_flag_i;      // R08
        evt_word[`AESMB_BIT_OVF]  = credit_overflow_flag_i;       // R09
        evt_word[`AESMB_BIT_UNXP] = unmatched_completion_flag_i;  // R10
        evt_word[`AESMB_BIT_CA]   = completer_abort_flag_i;       // R11
        evt_word[`AESMB_BIT_CTO]  = completion_timeout_flag_i;    // R12
        evt_word[`AESMB_BIT_FC]   = flow_control_protocol_flag_i; // R13
        evt_word[`AESMB_BIT_PSN]  = poisoned_packet_flag_i;       // R14
        evt_word[`AESMB_BIT_DLL]  = link_protocol_flag_i;         // R15
    end

    ////////////////////////////////////////////////////////////////////////
    // address decode

    aesmb_sel_t sel;
    logic [9:0] addr_dw;

    assign addr_dw = dword_of(cfg_addr_i);

    always_comb begin
        if (addr_dw == dword_of(`AESMB_OFS_CAP_ID)) begin
            sel = AESMB_SEL_CAP;
        end else if (addr_dw == dword_of(`AESMB_OFS_FLAGS)) begin
            sel = AESMB_SEL_FLAGS;
        end else if (addr_dw == dword_of(`AESMB_OFS_MASKS)) begin
            sel = AESMB_SEL_MASKS;
        end else begin
            sel = AESMB_SEL_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register next values

    logic [31:0] flags_q;
    logic [31:0] flags_d;
    logic [31:0] masks_q;
    logic [31:0] masks_d;
    logic [31:0] report_q;
    logic [31:0] report_d;
    logic [31:0] clr_vec;
    logic [31:0] set_vec;
    logic [31:0] wr_lanes;

    assign wr_lanes = lane_bits(cfg_be_i) & `AESMB_IMPL_MASK; // R16
    assign clr_vec  = (cfg_wr_i && sel == AESMB_SEL_FLAGS) ?
                      (cfg_wdata_i & wr_lanes) : 32'h0000_0000; // R05
    assign set_vec  = evt_word & ~masks_q & `AESMB_IMPL_MASK; // R17
    assign flags_d  = (flags_q & ~clr_vec) | set_vec; // R05 R21
    assign masks_d  = (cfg_wr_i && sel == AESMB_SEL_MASKS) ?
                      ((masks_q & ~wr_lanes) | (cfg_wdata_i & wr_lanes)) :
                      masks_q; // R18
    assign report_d = set_vec; // R17

    ////////////////////////////////////////////////////////////////////////
    // read data

    logic [31:0] hdr_word;
    logic [11:0] next_ptr;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic        rvalid_q;

    assign next_ptr = virtual_channel_structure_enable_i ?
                      `AESMB_NEXT_VC : `AESMB_NEXT_END; // R02 R03
    assign hdr_word = {next_ptr, `AESMB_VER_VAL, `AESMB_CAP_ID_VAL}; // R01 R04

    always_comb begin
        case (sel)
            AESMB_SEL_CAP: begin
                rdata_d = hdr_word;
            end
            AESMB_SEL_FLAGS: begin
                rdata_d = flags_q & `AESMB_IMPL_MASK; // R16
            end
            AESMB_SEL_MASKS: begin
                rdata_d = masks_q & `AESMB_IMPL_MASK; // R16
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // storage

    always_ff @(posedge ref_clk_i) begin
        if (bank_clear) begin
            flags_q  <= `AESMB_FLAGS_RST; // R19
            masks_q  <= `AESMB_MASKS_RST; // R19
        end else begin
            flags_q  <= flags_d;
            masks_q  <= masks_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (bank_clear || hot_reset_i) begin
            report_q <= 32'h0000_0000; // R20
        end else begin
            report_q <= report_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_q  <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= cfg_rd_i;
            if (cfg_rd_i) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign cfg_rdata_o      = rdata_q;
    assign cfg_rvalid_o     = rvalid_q;
    assign error_flags_o    = flags_q;
    assign error_suppress_o = masks_q;
    assign error_report_o   = report_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic rd_cap;
    assign rd_cap = cfg_rd_i && sel == AESMB_SEL_CAP;

    property p_cap_id;
        @(posedge ref_clk_i) disable iff (rst_i)
        rd_cap |=> cfg_rvalid_o && cfg_rdata_o[15:0] == 16'h0001;
    endproperty
    a_cap_id: assert property (p_cap_id) // R01
        else $error("capability identifier read wrong");

    property p_next_end;
        @(posedge ref_clk_i) disable iff (rst_i)
        rd_cap && !virtual_channel_structure_enable_i |=>
            cfg_rdata_o[31:20] == 12'h000;
    endproperty
    a_next_end: assert property (p_next_end) // R02
        else $error("next pointer not end of list");

    property p_next_vc;
        @(posedge ref_clk_i) disable iff (rst_i)
        rd_cap && virtual_channel_structure_enable_i |=>
            cfg_rdata_o[31:20] == 12'h150;
    endproperty
    a_next_vc: assert property (p_next_vc) // R03
        else $error("next pointer not at vc structure");

    property p_version;
        @(posedge ref_clk_i) disable iff (rst_i)
        rd_cap ##1 cfg_rd_i && sel == AESMB_SEL_CAP |=>
            cfg_rdata_o[19:16] == 4'h1 && $stable(cfg_rdata_o[19:0]);
    endproperty
    a_version: assert property (p_version) // R04
        else $error("capability version wrong or changing");

    property p_sticky;
        @(posedge ref_clk_i) disable iff (bank_clear)
        1'b1 |=> (($past(flags_q) & ~$past(clr_vec) & ~flags_q) == 32'h0);
    endproperty
    a_sticky: assert property (p_sticky) // R05
        else $error("status bit lost without clear");

    property p_ur_sets;
        @(posedge ref_clk_i) disable iff (bank_clear)
        unsupported_request_flag_i && !masks_q[20] |=> flags_q[20];
    endproperty
    a_ur_sets: assert property (p_ur_sets) // R06
        else $error("unsupported request not recorded");

    property p_events_set;
        @(posedge ref_clk_i) disable iff (bank_clear)
        (evt_word & ~masks_q) != 32'h0 |=>
            (($past(evt_word) & ~$past(masks_q) & ~flags_q) == 32'h0);
    endproperty
    a_events_set: assert property (p_events_set) // R07
        else $error("unmasked error not recorded");

    property p_reserved;
        @(posedge ref_clk_i) disable iff (rst_i)
        ((flags_q | masks_q) & 32'hffe0_0fef) == 32'h0;
    endproperty
    a_reserved: assert property (p_reserved) // R16
        else $error("reserved bit set");

    property p_masked;
        @(posedge ref_clk_i) disable iff (bank_clear)
        1'b1 |=> ((flags_q & ~$past(flags_q) & $past(masks_q)) == 32'h0) &&
                 ((error_report_o & $past(masks_q)) == 32'h0);
    endproperty
    a_masked: assert property (p_masked) // R17
        else $error("masked error leaked");

    property p_mask_write;
        @(posedge ref_clk_i) disable iff (bank_clear)
        cfg_wr_i && sel == AESMB_SEL_MASKS && cfg_be_i == 4'hf |=>
            masks_q == ($past(cfg_wdata_i) & 32'h001f_f010);
    endproperty
    a_mask_write: assert property (p_mask_write) // R18
        else $error("mask write not stored");

    property p_clear;
        @(posedge ref_clk_i)
        bank_clear |=> flags_q == 32'h0 && masks_q == 32'h0;
    endproperty
    a_clear: assert property (p_clear) // R19
        else $error("reset left status or mask set");

    property p_set_wins;
        @(posedge ref_clk_i) disable iff (bank_clear)
        (set_vec & clr_vec) != 32'h0 |=>
            (($past(set_vec) & ~flags_q) == 32'h0);
    endproperty
    a_set_wins: assert property (p_set_wins) // R21
        else $error("event lost to same-cycle clear");

    property p_poisoned_sets;
        @(posedge ref_clk_i) disable iff (bank_clear)
        poisoned_packet_flag_i && !masks_q[`AESMB_BIT_PSN] |=> flags_q[`AESMB_BIT_PSN];
    endproperty
    a_poisoned_sets: assert property (p_poisoned_sets) // R14
        else $error("poisoned packet not recorded");

    property p_dll_sets;
        @(posedge ref_clk_i) disable iff (bank_clear)
        link_protocol_flag_i && !masks_q[`AESMB_BIT_DLL] |=> flags_q[`AESMB_BIT_DLL];
    endproperty
    a_dll_sets: assert property (p_dll_sets) // R15
        else $error("link protocol error not recorded");

    property p_reserved_read;
        @(posedge ref_clk_i) disable iff (rst_i)
        cfg_rd_i && sel != AESMB_SEL_CAP |=>
            (cfg_rdata_o & ~`AESMB_IMPL_MASK) == 32'h0;
    endproperty
    a_reserved_read: assert property (p_reserved_read) // R16
        else $error("reserved bit read as one");

    property p_hot_keeps;
        @(posedge ref_clk_i) disable iff (rst_i)
        hot_reset_i && !bank_clear && !cfg_wr_i |=>
            flags_q == ($past(flags_q) | $past(set_vec)) && masks_q == $past(masks_q);
    endproperty
    a_hot_keeps: assert property (p_hot_keeps) // R20
        else $error("hot reset changed status or mask");

    property p_hot_report;
        @(posedge ref_clk_i) disable iff (rst_i)
        hot_reset_i |=> error_report_o == 32'h0;
    endproperty
    a_hot_report: assert property (p_hot_report) // R20
        else $error("report pulse survived hot reset");

endmodule

// >>> tb_advanced_error_status_mask_bank.sv
// self-checking bench for the advanced error status and mask bank
// assumes aesmb_bank and aesmb_consts.svh are compiled alongside
`timescale 1ns/1ps
`include "aesmb_consts.svh"

module tb_advanced_error_status_mask_bank;

    ////////////////////////////////////////////////////////////////////////////////
    logic        ref_clk_i    = 1'b0;
    logic        rst_i        = 1'b1;
    logic        link_reset_i = 1'b0;
    logic        hot_reset_i  = 1'b0;
    logic        gpin_n       = 1'b1;
    logic        vc_en        = 1'b0;
    logic        rd           = 1'b0;
    logic        wr           = 1'b0;
    logic [11:0] addr         = 12'h000;
    logic [3:0]  be           = 4'h0;
    logic [31:0] wdata        = 32'h0000_0000;
    logic [9:0]  err          = 10'h000;
    wire  [31:0] rdata;
    wire  [31:0] flags;
    wire  [31:0] supp;
    wire  [31:0] report;
    wire         rvalid;
    logic [31:0] exp_q[$];
    logic [31:0] flags_m;
    logic [31:0] mask_m;
    logic [9:0]  e;
    integer      seed       = 7339;
    integer      fail_count = 0;
    integer      n_checks   = 0;
    integer      cyc_cnt    = 0;

    always #4 ref_clk_i = ~ref_clk_i;

    aesmb_bank uut (
        .ref_clk_i                          (ref_clk_i),
        .rst_i                              (rst_i),
        .link_reset_i                       (link_reset_i),
        .hot_reset_i                        (hot_reset_i),
        .global_reset_pin_n_i               (gpin_n),
        .virtual_channel_structure_enable_i (vc_en),
        .cfg_rd_i                           (rd),
        .cfg_wr_i                           (wr),
        .cfg_addr_i                         (addr),
        .cfg_be_i                           (be),
        .cfg_wdata_i                        (wdata),
        .cfg_rdata_o                        (rdata),
        .cfg_rvalid_o                       (rvalid),
        .unsupported_request_flag_i         (err[9]),
        .end_to_end_crc_flag_i              (err[8]),
        .malformed_packet_flag_i            (err[7]),
        .credit_overflow_flag_i             (err[6]),
        .unmatched_completion_flag_i        (err[5]),
        .completer_abort_flag_i             (err[4]),
        .completion_timeout_flag_i          (err[3]),
        .flow_control_protocol_flag_i       (err[2]),
        .poisoned_packet_flag_i             (err[1]),
        .link_protocol_flag_i               (err[0]),
        .error_flags_o                      (flags),
        .error_suppress_o                   (supp),
        .error_report_o                     (report)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // event vector to status bit positions
    function automatic logic [31:0] spread(input logic [9:0] v);
        return {11'h000, v[9:1], 7'h00, v[0], 4'h0};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        n_checks = n_checks + 1;
        if (seen !== expv) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic cyc(input logic r, input logic w, input logic [11:0] a,
                       input logic [3:0] b, input logic [31:0] d, input logic [9:0] ev);
        @(negedge ref_clk_i);
        rd    = r;
        wr    = w;
        addr  = a;
        be    = b;
        wdata = d;
        err   = ev;
        @(negedge ref_clk_i);
        rd  = 1'b0;
        wr  = 1'b0;
        err = 10'h000;
    endtask

    task automatic rdx(input logic [11:0] a, input logic [31:0] expv);
        exp_q.push_back(expv);
        cyc(1'b1, 1'b0, a, 4'h0, 32'h0000_0000, 10'h000);
    endtask

    task automatic rdb(input logic [11:0] a, input logic [31:0] expv);
        exp_q.push_back(expv);
        exp_q.push_back(expv);
        @(negedge ref_clk_i);
        rd   = 1'b1;
        addr = a;
        repeat (2) @(negedge ref_clk_i);
        rd = 1'b0;
    endtask

    task automatic wrx(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
        cyc(1'b0, 1'b1, a, b, d, 10'h000);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // read data monitor
    always @(negedge ref_clk_i) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                fail_count = fail_count + 1;
                $display("unexpected at %0t: read answer with none pending", $time);
            end else begin
                chk(rdata, exp_q.pop_front());
            end
        end
    end

    always @(posedge ref_clk_i) begin
        cyc_cnt = cyc_cnt + 1;
        if (cyc_cnt == 3000) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: run did not finish", $time);
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(negedge ref_clk_i);
        rst_i = 1'b0;
        // header, reset values, read-only and unmapped places
        rdx(12'h100, 32'h0001_0001);
        rdx(12'h104, 32'h0000_0000);
        rdx(12'h108, 32'h0000_0000);
        vc_en = 1'b1;
        rdx(12'h102, 32'h1501_0001);
        rdb(12'h100, 32'h1501_0001);
        wrx(12'h100, 4'hf, 32'hffff_ffff);
        rdx(12'h100, 32'h1501_0001);
        rdx(12'h10c, 32'h0000_0000);
        vc_en = 1'b0;
        wrx(12'h108, 4'hf, 32'hffff_ffff);
        rdx(12'h108, `AESMB_IMPL_MASK);
        wrx(12'h108, 4'hf, 32'h0000_0000);
        $display("test header done");
        // each detector alone
        flags_m = 32'h0000_0000;
        for (int i = 0; i < 10; i++) begin
            cyc(1'b0, 1'b0, 12'h000, 4'h0, 32'h0, 10'h001 << i);
            flags_m = flags_m | spread(10'h001 << i);
            chk(report, spread(10'h001 << i));
            chk(flags, flags_m);
        end
        rdx(12'h104, `AESMB_IMPL_MASK);
        $display("test detectors done");
        // clearing by writing ones, lanes and same-cycle event
        wrx(12'h104, 4'hf, 32'h0000_0000);
        chk(flags, flags_m);
        wrx(12'h104, 4'h4, 32'hffff_ffff);
        flags_m = flags_m & ~32'h00ff_0000;
        chk(flags, flags_m);
        cyc(1'b0, 1'b1, 12'h104, 4'hf, 32'h0000_1000, 10'h002);
        chk(flags, flags_m);
        wrx(12'h104, 4'hf, 32'h0000_1010);
        flags_m = flags_m & ~32'h0000_1010;
        chk(flags, flags_m);
        rdx(12'h104, flags_m);
        wrx(12'h104, 4'hf, 32'hffff_ffff);
        chk(flags, 32'h0000_0000);
        $display("test clearing done");
        // random masks against random events
        for (int k = 0; k < 6; k++) begin
            mask_m = $random(seed);
            e = 10'($random(seed));
            wrx(12'h108, 4'hf, mask_m);
            mask_m = mask_m & `AESMB_IMPL_MASK;
            chk(supp, mask_m);
            cyc(1'b0, 1'b0, 12'h000, 4'h0, 32'h0, e);
            chk(report, spread(e) & ~mask_m);
            chk(flags, spread(e) & ~mask_m);
            rdx(12'h108, mask_m);
            wrx(12'h104, 4'hf, 32'hffff_ffff);
        end
        $display("test masking done");
        // link and global reset clear status and mask, hot reset keeps them
        flags_m = `AESMB_IMPL_MASK & ~32'h0000_0010;
        for (int s = 0; s < 3; s++) begin
            wrx(12'h108, 4'hf, 32'h0000_0010);
            cyc(1'b0, 1'b0, 12'h000, 4'h0, 32'h0, 10'h3ff);
            chk(flags, flags_m);
            @(negedge ref_clk_i);
            link_reset_i = (s == 0);
            hot_reset_i  = (s == 1);
            gpin_n       = (s != 2);
            repeat (8) @(negedge ref_clk_i);
            link_reset_i = 1'b0;
            hot_reset_i  = 1'b0;
            gpin_n       = 1'b1;
            repeat (8) @(negedge ref_clk_i);
            chk(flags, (s == 1) ? flags_m : 32'h0000_0000);
            chk(supp, (s == 1) ? 32'h0000_0010 : 32'h0000_0000);
        end
        $display("test resets done");
        repeat (3) @(negedge ref_clk_i);
        chk(exp_q.size(), 32'h0000_0000);
        wrap_up();
    end

endmodule
